// File: src/cpuil_pkg.sv
// Shared constants and types for the instruction length and timing decoder.
// Assumes a single processor clock; one execution cycle equals one clock period.

package cpuil_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int OP_W = 8;
   localparam int LEN_W = 2;
   localparam int CYC_W = 3;

   // ---------------------------------------------------------------
   // Instruction lengths in bytes
   // ---------------------------------------------------------------
   localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
   localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
   localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

   // ---------------------------------------------------------------
   // Execution cycles, one clock period each
   // ---------------------------------------------------------------
   localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
   localparam logic [CYC_W-1:0] CYC_TWO = 3'h2;
   localparam logic [CYC_W-1:0] CYC_THREE = 3'h3;
   localparam logic [CYC_W-1:0] CYC_FOUR = 3'h4;

   // ---------------------------------------------------------------
   // Decode result
   // ---------------------------------------------------------------
   typedef struct packed {
      logic known;
      logic aux;
      logic [LEN_W-1:0] len;
      logic [CYC_W-1:0] cyc;
   } cpuil_dec_s;

   // Opcodes outside the covered groups pass as one byte, one cycle
   localparam cpuil_dec_s DEC_NONE = '{known: 1'b0, aux: 1'b0, len: LEN_ONE, cyc: CYC_ONE};

   function automatic cpuil_dec_s cpuil_mk(input logic [LEN_W-1:0] len,
                                           input logic [CYC_W-1:0] cyc);
      cpuil_dec_s r;
      r.known = 1'b1;
      r.aux = 1'b0;
      r.len = len;
      r.cyc = cyc;
      return r;
   endfunction

endpackage

// File: src/cpuil_timing.sv
// Opcode decoder giving byte length and execution-cycle count, plus a
// cycle sequencer that holds the core busy for exactly that many clocks.
// Assumes opcodes arrive from logic on the same clock with a valid strobe.
//
// Function
// - Register to accumulator move: one byte, one cycle.
// - Direct byte to accumulator: two bytes, two cycles.
// - Indirect RAM to accumulator: one byte, two cycles.
// - Immediate to accumulator: two bytes, two cycles.
// - Accumulator to register: one byte, two cycles.
// - Direct byte to register: two bytes, four cycles.
// - Immediate to register: two bytes, two cycles.
// - Accumulator or register to direct byte: two bytes, three cycles.
// - Direct to direct move: three bytes, four cycles.
// - Indirect RAM to direct byte: two bytes, four cycles.
// - Immediate to direct byte: three bytes, three cycles.
// - Stores to indirect RAM: three cycles; accumulator one byte, others two.
// - Data pointer constant load: three bytes, three cycles.
// - Code byte reads via data pointer or program counter: one byte, four cycles.
// - Auxiliary RAM moves, either width or direction: one byte, three cycles.
// - Auxiliary moves never reach external RAM.
// - Push: two bytes, four cycles; pop: two bytes, three cycles.
// - Exchanges: register 3/1, direct 4/2, indirect and low digit 4/1.
// - Add: register and immediate two cycles, direct and indirect three.
// - Add with carry matches plain add in size and timing.

`timescale 1ns/10ps

module cpuil_timing (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic OP_VALID_I,
   input wire logic [cpuil_pkg::OP_W-1:0] OP_I,
   output logic READY_O,
   output logic BUSY_O,
   output logic FETCH_O,
   output logic KNOWN_O,
   output logic AUX_O,
   output logic [cpuil_pkg::LEN_W-1:0] LEN_O,
   output logic [cpuil_pkg::CYC_W-1:0] CYC_O
);
   import cpuil_pkg::*;

   // ---------------------------------------------------------------
   // Decoder
   // ---------------------------------------------------------------
   function automatic cpuil_dec_s decode(input logic [OP_W-1:0] op);
      cpuil_dec_s r;
      r = DEC_NONE;
      casez (op)
         8'b1110_1???: r = cpuil_mk(LEN_ONE, CYC_ONE);
         8'hE5: r = cpuil_mk(LEN_TWO, CYC_TWO);
         8'b1110_011?: r = cpuil_mk(LEN_ONE, CYC_TWO);
         8'h74: r = cpuil_mk(LEN_TWO, CYC_TWO);
         8'b1111_1???: r = cpuil_mk(LEN_ONE, CYC_TWO);
         8'b1010_1???: r = cpuil_mk(LEN_TWO, CYC_FOUR);
         8'b0111_1???: r = cpuil_mk(LEN_TWO, CYC_TWO);
         8'hF5, 8'b1000_1???: r = cpuil_mk(LEN_TWO, CYC_THREE);
         8'h85: r = cpuil_mk(LEN_THREE, CYC_FOUR);
         8'b1000_011?: r = cpuil_mk(LEN_TWO, CYC_FOUR);
         8'h75: r = cpuil_mk(LEN_THREE, CYC_THREE);
         8'b1111_011?: r = cpuil_mk(LEN_ONE, CYC_THREE);
         8'b1010_011?, 8'b0111_011?: r = cpuil_mk(LEN_TWO, CYC_THREE);
         8'h90: r = cpuil_mk(LEN_THREE, CYC_THREE);
         8'h93, 8'h83: r = cpuil_mk(LEN_ONE, CYC_FOUR);
         8'b1110_001?, 8'hE0, 8'b1111_001?, 8'hF0: begin
            r = cpuil_mk(LEN_ONE, CYC_THREE);
            r.aux = 1'b1;
         end
         8'hC0: r = cpuil_mk(LEN_TWO, CYC_FOUR);
         8'hD0: r = cpuil_mk(LEN_TWO, CYC_THREE);
         8'b1100_1???: r = cpuil_mk(LEN_ONE, CYC_THREE);
         8'hC5: r = cpuil_mk(LEN_TWO, CYC_FOUR);
         8'b1100_011?, 8'b1101_011?: r = cpuil_mk(LEN_ONE, CYC_FOUR);
         8'b0010_1???, 8'b0011_1???: r = cpuil_mk(LEN_ONE, CYC_TWO);
         8'h25, 8'h35: r = cpuil_mk(LEN_TWO, CYC_THREE);
         8'b0010_011?, 8'b0011_011?: r = cpuil_mk(LEN_ONE, CYC_THREE);
         8'h24, 8'h34: r = cpuil_mk(LEN_TWO, CYC_TWO);
         default: r = DEC_NONE;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_EXEC} cpuil_state_e;

   cpuil_state_e state_q, state_d;
   cpuil_dec_s dec_q, dec_d;
   logic [CYC_W-1:0] cnt_q, cnt_d;
   logic ready_q, ready_d;
   logic busy_q, busy_d;
   logic fetch_q, fetch_d;

   wire accept = OP_VALID_I && ready_q;
   wire cpuil_dec_s dec_now = decode(OP_I);
   wire last_cycle = (state_q == ST_EXEC) && (cnt_q == CYC_ONE);

   always_comb begin
      state_d = state_q;
      dec_d = dec_q;
      cnt_d = cnt_q;
      ready_d = ready_q;
      busy_d = busy_q;
      fetch_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (accept) begin
               state_d = ST_EXEC;
               dec_d = dec_now;
               cnt_d = dec_now.cyc;
               ready_d = 1'b0;
               busy_d = 1'b1;
            end
         end
         ST_EXEC: begin
            cnt_d = cnt_q - CYC_ONE;
            if (last_cycle) begin
               state_d = ST_IDLE;
               ready_d = 1'b1;
               busy_d = 1'b0;
               fetch_d = 1'b1;
            end
         end
      endcase
   end

   // Results stand until the next accepted opcode
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_q <= ST_IDLE;
         dec_q <= DEC_NONE;
         cnt_q <= '0;
         ready_q <= 1'b1;
         busy_q <= 1'b0;
         fetch_q <= 1'b0;
      end else begin
         state_q <= state_d;
         dec_q <= dec_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
         busy_q <= busy_d;
         fetch_q <= fetch_d;
      end
   end

   assign READY_O = ready_q;
   assign BUSY_O = busy_q;
   assign FETCH_O = fetch_q;
   assign KNOWN_O = dec_q.known;
   assign AUX_O = dec_q.aux;
   assign LEN_O = dec_q.len;
   assign CYC_O = dec_q.cyc;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   // Counts the busy clocks of the current instruction
   logic [CYC_W-1:0] run_q;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         run_q <= '0;
      end else if (accept) begin
         run_q <= '0;
      end else if (busy_q) begin
         run_q <= run_q + CYC_ONE;
      end
   end

   property p_mov_a_rn;
      accept && ((OP_I & 8'hF8) == 8'hE8) |=> LEN_O == 2'h1 && CYC_O == 3'h1;
   endproperty
   a_mov_a_rn: assert property (p_mov_a_rn) else $error("reg to acc timing");

   property p_mov_a_dir;
      accept && OP_I == 8'hE5 ##1 1'b1 |-> LEN_O == 2'h2 && CYC_O == 3'h2 && KNOWN_O;
   endproperty
   a_mov_a_dir: assert property (p_mov_a_dir) else $error("direct to acc timing");

   property p_mov_a_ind;
      accept && ((OP_I & 8'hFE) == 8'hE6) |=> BUSY_O [*2] ##1 !BUSY_O && LEN_O == 2'h1;
   endproperty
   a_mov_a_ind: assert property (p_mov_a_ind) else $error("indirect to acc timing");

   property p_mov_a_imm;
      accept && OP_I == 8'h74 |=> LEN_O == 2'h2 && CYC_O == 3'h2;
   endproperty
   a_mov_a_imm: assert property (p_mov_a_imm) else $error("immediate to acc timing");

   property p_mov_rn_a;
      accept && ((OP_I & 8'hF8) == 8'hF8) |=> LEN_O == 2'h1 && CYC_O == 3'h2;
   endproperty
   a_mov_rn_a: assert property (p_mov_rn_a) else $error("acc to reg timing");

   property p_mov_rn_dir;
      accept && ((OP_I & 8'hF8) == 8'hA8) |=> BUSY_O [*4] ##1 FETCH_O && LEN_O == 2'h2;
   endproperty
   a_mov_rn_dir: assert property (p_mov_rn_dir) else $error("direct to reg timing");

   property p_mov_rn_imm;
      accept && ((OP_I & 8'hF8) == 8'h78) |=> LEN_O == 2'h2 && CYC_O == 3'h2;
   endproperty
   a_mov_rn_imm: assert property (p_mov_rn_imm) else $error("immediate to reg timing");

   property p_mov_dir_src;
      accept && (OP_I == 8'hF5 || (OP_I & 8'hF8) == 8'h88) |=> LEN_O == 2'h2 && CYC_O == 3'h3;
   endproperty
   a_mov_dir_src: assert property (p_mov_dir_src) else $error("store to direct timing");

   property p_mov_dir_dir;
      accept && OP_I == 8'h85 |=> LEN_O == 2'h3 && CYC_O == 3'h4;
   endproperty
   a_mov_dir_dir: assert property (p_mov_dir_dir) else $error("direct to direct timing");

   property p_mov_dir_ind;
      accept && ((OP_I & 8'hFE) == 8'h86) |=> LEN_O == 2'h2 && CYC_O == 3'h4;
   endproperty
   a_mov_dir_ind: assert property (p_mov_dir_ind) else $error("indirect to direct timing");

   property p_mov_dir_imm;
      accept && OP_I == 8'h75 |=> LEN_O == 2'h3 && CYC_O == 3'h3;
   endproperty
   a_mov_dir_imm: assert property (p_mov_dir_imm) else $error("immediate to direct timing");

   property p_mov_ind_dst;
      accept && ((OP_I & 8'hFE) == 8'hF6 || (OP_I & 8'hFE) == 8'hA6 || (OP_I & 8'hFE) == 8'h76)
         |=> CYC_O == 3'h3 && LEN_O == ($past(OP_I[7:4]) == 4'hF ? 2'h1 : 2'h2);
   endproperty
   a_mov_ind_dst: assert property (p_mov_ind_dst) else $error("store to indirect timing");

   property p_data_pointer_load;
      accept && OP_I == 8'h90 |=> LEN_O == 2'h3 && CYC_O == 3'h3;
   endproperty
   a_data_pointer_load: assert property (p_data_pointer_load)
      else $error("pointer load timing");

   property p_code_read;
      accept && (OP_I == 8'h93 || OP_I == 8'h83) |=> LEN_O == 2'h1 && CYC_O == 3'h4;
   endproperty
   a_code_read: assert property (p_code_read) else $error("code byte read timing");

   property p_aux_move;
      accept && ((OP_I & 8'hEE) == 8'hE2 || (OP_I & 8'hEF) == 8'hE0)
         |=> LEN_O == 2'h1 && CYC_O == 3'h3;
   endproperty
   a_aux_move: assert property (p_aux_move) else $error("aux move timing");

   property p_aux_onchip;
      accept && ((OP_I & 8'hEE) == 8'hE2 || (OP_I & 8'hEF) == 8'hE0) |=> AUX_O && KNOWN_O;
   endproperty
   a_aux_onchip: assert property (p_aux_onchip) else $error("aux move not on-chip");

   property p_stack;
      accept && (OP_I == 8'hC0 || OP_I == 8'hD0)
         |=> LEN_O == 2'h2 && CYC_O == ($past(OP_I) == 8'hC0 ? 3'h4 : 3'h3);
   endproperty
   a_stack: assert property (p_stack) else $error("push or pop timing");

   property p_exchange;
      accept && ((OP_I & 8'hF8) == 8'hC8) |=> LEN_O == 2'h1 && CYC_O == 3'h3;
   endproperty
   a_exchange: assert property (p_exchange) else $error("register exchange timing");

   property p_exchange_mem;
      accept && (OP_I == 8'hC5 || (OP_I & 8'hEE) == 8'hC6)
         |=> CYC_O == 3'h4 && LEN_O == ($past(OP_I) == 8'hC5 ? 2'h2 : 2'h1);
   endproperty
   a_exchange_mem: assert property (p_exchange_mem) else $error("memory exchange timing");

   property p_add;
      accept && ((OP_I & 8'hE0) == 8'h20) && (OP_I[3] || OP_I[2:0] >= 3'h4)
         |=> CYC_O == (($past(OP_I[3]) || $past(OP_I[2:0]) == 3'h4) ? 3'h2 : 3'h3);
   endproperty
   a_add: assert property (p_add) else $error("add timing");

   property p_add_carry;
      accept && ((OP_I & 8'hF0) == 8'h30) && (OP_I[3] || OP_I[2:0] >= 3'h4)
         |=> LEN_O == (($past(OP_I[3]) || $past(OP_I[1])) ? 2'h1 : 2'h2);
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add with carry length");

   // A reset that cuts an instruction short also drops busy; that is no completion
   property p_busy_length;
      $fell(BUSY_O) && !$past(RST_I) |-> run_q == CYC_O && FETCH_O && READY_O;
   endproperty
   a_busy_length: assert property (p_busy_length) else $error("busy length mismatch");

   property p_fetch_pulse;
      FETCH_O |=> !FETCH_O;
   endproperty
   a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch not one cycle");

endmodule

// File: sim/tb_cpu_instr_length_timing.sv
// Self-checking bench for the opcode length and timing decoder.
// Assumes the decoder's own ports only; inputs change at the falling edge.

`timescale 1ns/10ps

module tb_cpu_instr_length_timing;
   import cpuil_pkg::*;

   logic CLK_I;
   logic RST_I;
   logic OP_VALID_I;
   logic [OP_W-1:0] OP_I;
   logic READY_O;
   logic BUSY_O;
   logic FETCH_O;
   logic KNOWN_O;
   logic AUX_O;
   logic [LEN_W-1:0] LEN_O;
   logic [CYC_W-1:0] CYC_O;
   int fails;
   int n_compared;

   cpuil_timing DUT (
      .CLK_I(CLK_I),
      .RST_I(RST_I),
      .OP_VALID_I(OP_VALID_I),
      .OP_I(OP_I),
      .READY_O(READY_O),
      .BUSY_O(BUSY_O),
      .FETCH_O(FETCH_O),
      .KNOWN_O(KNOWN_O),
      .AUX_O(AUX_O),
      .LEN_O(LEN_O),
      .CYC_O(CYC_O)
   );

   initial begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic present(input logic [7:0] op);
      OP_VALID_I = 1'b1;
      OP_I = op;
   endtask

   task automatic check_reset;
      chk("ready", READY_O, 8'h01);
      chk("busy", BUSY_O, 8'h00);
      chk("fetch", FETCH_O, 8'h00);
      chk("known", KNOWN_O, 8'h00);
      chk("aux", AUX_O, 8'h00);
      chk("len", LEN_O, 8'h01);
      chk("cyc", CYC_O, 8'h01);
   endtask

   // Opcode already on the pins; nxt[8] keeps the strobe up during busy
   task automatic run_op(input logic [1:0] len, input logic [2:0] cyc, input logic kn,
                         input logic ax, input logic [8:0] nxt);
      int k;
      chk("ready", READY_O, 8'h01);
      @(negedge CLK_I);
      OP_VALID_I = nxt[8];
      OP_I = nxt[7:0];
      for (k = 0; k < cyc; k++) begin
         if (k > 0) @(negedge CLK_I);
         chk("len", LEN_O, len);
         chk("cyc", CYC_O, cyc);
         chk("known", KNOWN_O, kn);
         chk("aux", AUX_O, ax);
         chk("busy", BUSY_O, 8'h01);
         chk("ready", READY_O, 8'h00);
         chk("fetch", FETCH_O, 8'h00);
      end
      @(negedge CLK_I);
      chk("busy", BUSY_O, 8'h00);
      chk("ready", READY_O, 8'h01);
      chk("fetch", FETCH_O, 8'h01);
   endtask

   task automatic t_group(input logic [7:0] op0, input int n, input logic [1:0] len,
                          input logic [2:0] cyc, input logic ax);
      int i;
      for (i = 0; i < n; i++) begin
         present(op0 + i[7:0]);
         run_op(len, cyc, 1'b1, ax, 9'h000);
         @(negedge CLK_I);
         chk("fetch", FETCH_O, 8'h00);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_table;
      t_group(8'hE8, 8, 2'h1, 3'h1, 1'b0);
      t_group(8'hE5, 1, 2'h2, 3'h2, 1'b0);
      t_group(8'hE6, 2, 2'h1, 3'h2, 1'b0);
      t_group(8'h74, 1, 2'h2, 3'h2, 1'b0);
      t_group(8'hF8, 8, 2'h1, 3'h2, 1'b0);
      t_group(8'hA8, 8, 2'h2, 3'h4, 1'b0);
      t_group(8'h78, 8, 2'h2, 3'h2, 1'b0);
      t_group(8'hF5, 1, 2'h2, 3'h3, 1'b0);
      t_group(8'h88, 8, 2'h2, 3'h3, 1'b0);
      t_group(8'h85, 1, 2'h3, 3'h4, 1'b0);
      t_group(8'h86, 2, 2'h2, 3'h4, 1'b0);
      t_group(8'h75, 1, 2'h3, 3'h3, 1'b0);
      t_group(8'hF6, 2, 2'h1, 3'h3, 1'b0);
      t_group(8'hA6, 2, 2'h2, 3'h3, 1'b0);
      t_group(8'h76, 2, 2'h2, 3'h3, 1'b0);
      t_group(8'h90, 1, 2'h3, 3'h3, 1'b0);
      t_group(8'h93, 1, 2'h1, 3'h4, 1'b0);
      t_group(8'h83, 1, 2'h1, 3'h4, 1'b0);
      t_group(8'hE2, 2, 2'h1, 3'h3, 1'b1);
      t_group(8'hE0, 1, 2'h1, 3'h3, 1'b1);
      t_group(8'hF2, 2, 2'h1, 3'h3, 1'b1);
      t_group(8'hF0, 1, 2'h1, 3'h3, 1'b1);
      t_group(8'hC0, 1, 2'h2, 3'h4, 1'b0);
      t_group(8'hD0, 1, 2'h2, 3'h3, 1'b0);
      t_group(8'hC8, 8, 2'h1, 3'h3, 1'b0);
      t_group(8'hC5, 1, 2'h2, 3'h4, 1'b0);
      t_group(8'hC6, 2, 2'h1, 3'h4, 1'b0);
      t_group(8'hD6, 2, 2'h1, 3'h4, 1'b0);
      t_group(8'h28, 8, 2'h1, 3'h2, 1'b0);
      t_group(8'h25, 1, 2'h2, 3'h3, 1'b0);
      t_group(8'h26, 2, 2'h1, 3'h3, 1'b0);
      t_group(8'h24, 1, 2'h2, 3'h2, 1'b0);
      t_group(8'h38, 8, 2'h1, 3'h2, 1'b0);
      t_group(8'h35, 1, 2'h2, 3'h3, 1'b0);
      t_group(8'h36, 2, 2'h1, 3'h3, 1'b0);
      t_group(8'h34, 1, 2'h2, 3'h2, 1'b0);
   endtask

   // Strobe held while busy must be ignored, then taken in the fetch cycle
   task automatic t_refuse_back_to_back;
      present(8'hA8);
      run_op(2'h2, 3'h4, 1'b1, 1'b0, 9'h185);
      run_op(2'h3, 3'h4, 1'b1, 1'b0, 9'h1E0);
      run_op(2'h1, 3'h3, 1'b1, 1'b1, 9'h194);
      // Unlisted opcode must clear the aux flag left behind
      run_op(2'h1, 3'h1, 1'b0, 1'b0, 9'h000);
      @(negedge CLK_I);
      chk("fetch", FETCH_O, 8'h00);
   endtask

   // Reset in the middle of a long instruction
   task automatic t_mid_reset;
      present(8'h85);
      @(negedge CLK_I);
      OP_VALID_I = 1'b0;
      @(negedge CLK_I);
      chk("busy", BUSY_O, 8'h01);
      RST_I = 1'b1;
      @(negedge CLK_I);
      RST_I = 1'b0;
      check_reset();
      @(negedge CLK_I);
      t_group(8'hE8, 1, 2'h1, 3'h1, 1'b0);
   endtask

   initial begin
      int k;
      fails = 0;
      n_compared = 0;
      RST_I = 1'b1;
      OP_VALID_I = 1'b0;
      OP_I = 8'h00;
      repeat (8) @(negedge CLK_I);
      check_reset();
      RST_I = 1'b0;
      @(negedge CLK_I);
      for (k = 0; k < 4 && READY_O !== 1'b1; k++) @(negedge CLK_I);
      if (READY_O !== 1'b1) begin
         fails++;
         report_and_stop();
      end
      check_reset();
      t_table();
      t_refuse_back_to_back();
      t_mid_reset();
      report_and_stop();
   end

endmodule
